// ===== design/sac_pkg.sv
// Shared constants, types and helpers for the serial converter control block
package sac_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int RES_W = 10;                 // Result width
   localparam int ADDR_W = 4;                 // Channel address width
   localparam int CNT_W = 5;                  // Link edge counter width
   localparam int RISE_W = 3;                 // Rising edge counter width
   localparam int DG_W = 8;                   // Deglitch counter width
   localparam int STEP_W = 3;                 // Per-bit settle counter width
   localparam int FIFO_DEPTH = 2;             // Result buffer entries

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int SYS_PERIOD_NS = 8;          // System clock period
   localparam int CS_SETUP_NS = 1425;         // Select setup before first address bit
   // Least time, so round up
   localparam int CS_SETUP_CYC = (CS_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   // Setup plus two further system clock edges
   localparam int DEGLITCH_CYC = CS_SETUP_CYC + 2;
   localparam logic [DG_W-1:0] DEGLITCH_LOAD = DG_W'(DEGLITCH_CYC);
   localparam logic [DG_W-1:0] DG_ONE = 8'h01;
   // Cycles per bit decision, covers comparator sync latency
   localparam int STEP_CYC = 4;
   localparam logic [STEP_W-1:0] STEP_LOAD = STEP_W'(STEP_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Link edge positions
   localparam logic [RISE_W-1:0] RISE_ADDR_DONE = 3'h4;  // Address bits taken
   localparam logic [CNT_W-1:0] FALL_SAMPLE = 5'h04;     // Sampling starts
   localparam logic [CNT_W-1:0] FALL_HOLD = 5'h0a;       // Sample held
   localparam logic [CNT_W-1:0] FALL_MAX = 5'h10;        // Counter saturation

   ////////////////////////////////////////////////////////////////////////////
   // Codes
   localparam logic [RES_W-1:0] CODE_FULL = 10'h3ff;     // Upper reference code
   localparam logic [RES_W-1:0] CODE_ZERO = 10'h000;     // Lower reference code
   localparam logic [RES_W-1:0] CODE_ONE = 10'h001;      // Trial bit seed
   localparam logic [3:0] BIT_MSB = 4'h9;                // Index of result MSB
   localparam logic [3:0] BIT_LSB = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_LAST_EXT = 4'ha;   // Last external input
   localparam logic [ADDR_W-1:0] ADDR_LAST = 4'hd;       // Last self-test input

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer states
   typedef enum logic [1:0] {
      CV_IDLE,
      CV_SAMPLE,
      CV_TRIAL,
      CV_DONE
   } sac_cv_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Gray helpers for the edge counter crossing
   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = '0;
      b[CNT_W-1] = g[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      gray2bin = b;
   endfunction

endpackage

// ===== design/sac_fifo2.sv
// Small valid/ready result buffer
`timescale 1ns/1ps
module sac_fifo2 #(
   parameter int W = 10,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_reg [DEPTH];         // Storage
   logic [W-1:0] mem_next [DEPTH];
   logic [AW-1:0] wr_reg, wr_next;        // Write pointer
   logic [AW-1:0] rd_reg, rd_next;        // Read pointer
   logic [AW:0] cnt_reg, cnt_next;        // Occupancy
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////////
   // Honest flags straight from occupancy
   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Next pointers, count and storage
   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_data_i;
         wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_reg + 1'b1);
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_reg + 1'b1);
      end
      // Simultaneous push and pop leaves the count alone
      if (push && !pop) begin
         cnt_next = (AW+1)'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = (AW+1)'(cnt_reg - 1'b1);
      end
   end

   // Register stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
      mem_reg <= mem_next;
   end

endmodule

// ===== design/sac_top.sv
// Select, abort and conversion sequencing for a 10-bit serial converter
//
// Behaviour
// - Select falling edge starts every operating sequence
// - Select falling mid-cycle aborts to initial state
// - Abort keeps previous result in output register
// - Bits decided one per step, MSB first
// - Clamp to all ones or all zeros
// - Ignore controls for setup plus two edges
// - Four address bits, MSB first, rising edges
// - Sample from fourth to tenth falling edge
// - Codes select eleven inputs and self-tests
// - Data output driven while select low
`timescale 1ns/1ps
module sac_top (
   input wire logic CLK_I,                 // System clock, 125 MHz
   input wire logic RST_I,                 // Synchronous reset, active high
   input wire logic SCLK_I,                // Serial transfer clock from host
   input wire logic CS_N_I,                // Select pin, active low
   input wire logic ADDR_I,                // Serial address pin
   input wire logic COMP_I,                // Comparator: input above trial level
   input wire logic OVER_REF_I,            // Input at or above upper reference
   input wire logic UNDER_REF_I,           // Input at or below lower reference
   output logic DATA_O,                    // Serial data out level
   output logic DATA_OE_N_O,               // Data pin enable, low drives
   output logic SAMPLE_O,                  // Sampling switch closed
   output logic [sac_pkg::ADDR_W-1:0] MUX_SEL_O, // Selected input
   output logic MUX_VALID_O,               // Selected code is a defined input
   output logic [sac_pkg::RES_W-1:0] DAC_CODE_O, // Trial code to capacitor array
   output logic EOC_O                      // High when no conversion runs
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: runs on the host's serial clock
   // Link logic held cleared until the deglitch wait ends
   logic armed_reg, armed_next;            // System side: controls accepted
   logic link_clr;                         // Asynchronous clear of link logic
   logic [sac_pkg::RISE_W-1:0] rise_cnt_reg, rise_cnt_next;   // Rising edges seen
   logic [sac_pkg::ADDR_W-1:0] addr_sh_reg, addr_sh_next;     // Address shifter
   logic [sac_pkg::CNT_W-1:0] fall_cnt_reg, fall_cnt_next;    // Falling edges seen
   logic [sac_pkg::CNT_W-1:0] fall_gray_reg, fall_gray_next;  // Gray copy to cross
   // The clock may stop outside a frame, so clearing comes from the frame itself
   assign link_clr = ~armed_reg;

   // Rising edge group: address capture
   always_comb begin
      rise_cnt_next = rise_cnt_reg;
      addr_sh_next = addr_sh_reg;
      if (rise_cnt_reg < sac_pkg::RISE_ADDR_DONE) begin
         addr_sh_next = {addr_sh_reg[sac_pkg::ADDR_W-2:0], ADDR_I};
         rise_cnt_next = sac_pkg::RISE_W'(rise_cnt_reg + 1'b1);
      end
   end

   // Registers on the rising edge; cleared while controls are ignored
   always_ff @(posedge SCLK_I or posedge link_clr) begin
      if (link_clr) begin
         rise_cnt_reg <= '0;
         addr_sh_reg <= '0;
      end else begin
         rise_cnt_reg <= rise_cnt_next;
         addr_sh_reg <= addr_sh_next;
      end
   end

   // Falling edge group: counts edges, gray coded for the crossing
   always_comb begin
      fall_cnt_next = fall_cnt_reg;
      // Saturate so the count never wraps back into the sample window
      if (fall_cnt_reg < sac_pkg::FALL_MAX) begin
         fall_cnt_next = sac_pkg::CNT_W'(fall_cnt_reg + 1'b1);
      end
      fall_gray_next = sac_pkg::bin2gray(fall_cnt_next);
   end

   // Registers on the falling edge
   always_ff @(negedge SCLK_I or posedge link_clr) begin
      if (link_clr) begin
         fall_cnt_reg <= '0;
         fall_gray_reg <= '0;
      end else begin
         fall_cnt_reg <= fall_cnt_next;
         fall_gray_reg <= fall_gray_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain: synchronisers
   logic cs_s1_reg, cs_s2_reg, cs_prev_reg;           // Select, two stages plus history
   logic [sac_pkg::CNT_W-1:0] fg_s1_reg, fg_s2_reg;   // Gray edge count
   logic [sac_pkg::ADDR_W-1:0] ad_s1_reg, ad_s2_reg;  // Captured address
   logic cmp_s1_reg, cmp_s2_reg;                      // Comparator
   logic ovr_s1_reg, ovr_s2_reg;                      // Upper limit flag
   logic und_s1_reg, und_s2_reg;                      // Lower limit flag
   // Select stages reset high, so no false fall follows reset
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_s1_reg <= CS_N_I;
         cs_s2_reg <= cs_s1_reg;
         cs_prev_reg <= cs_s2_reg;
      end
   end
   // Data stages run free: nothing reads them until the link is armed;
   // first stages feed only the second stages
   always_ff @(posedge CLK_I) begin
      fg_s1_reg <= fall_gray_reg;
      fg_s2_reg <= fg_s1_reg;
      // Address is quiet after the fourth rising edge, long before use
      ad_s1_reg <= addr_sh_reg;
      ad_s2_reg <= ad_s1_reg;
      cmp_s1_reg <= COMP_I;
      cmp_s2_reg <= cmp_s1_reg;
      ovr_s1_reg <= OVER_REF_I;
      ovr_s2_reg <= ovr_s1_reg;
      und_s1_reg <= UNDER_REF_I;
      und_s2_reg <= und_s1_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain: select handling and conversion sequencer
   logic cs_fall;                                       // Select went low
   logic [sac_pkg::DG_W-1:0] dg_reg, dg_next;           // Deglitch countdown
   logic [sac_pkg::CNT_W-1:0] fcnt;                     // Synced falling count
   logic [sac_pkg::CNT_W-1:0] fprev_reg, fprev_next;    // Count one cycle back
   logic smp_start, smp_hold;                           // Window edges
   sac_pkg::sac_cv_state_t st_reg, st_next;             // Sequencer state
   logic [3:0] bit_reg, bit_next;                       // Bit under trial
   logic [sac_pkg::STEP_W-1:0] step_reg, step_next;     // Settle countdown
   logic [sac_pkg::RES_W-1:0] acc_reg, acc_next;        // Bits decided so far
   logic [sac_pkg::RES_W-1:0] trial;                    // Accumulated plus trial bit
   logic [sac_pkg::RES_W-1:0] dac_next;
   logic [sac_pkg::ADDR_W-1:0] mux_next;
   logic mux_ok_next, sample_next, eoc_next;
   logic push_valid, push_ready;                        // Into the result buffer
   assign cs_fall = cs_prev_reg & ~cs_s2_reg;
   assign fcnt = sac_pkg::gray2bin(fg_s2_reg);
   assign trial = acc_reg | DAC_CODE_O;
   // Window edges only count while the link is live
   assign smp_start = armed_reg && (fcnt >= sac_pkg::FALL_SAMPLE)
                      && (fprev_reg < sac_pkg::FALL_SAMPLE);
   assign smp_hold = armed_reg && (fcnt >= sac_pkg::FALL_HOLD)
                     && (fprev_reg < sac_pkg::FALL_HOLD);
   assign push_valid = (st_reg == sac_pkg::CV_DONE) && !cs_fall;
   // Deglitch and sequencer next state
   always_comb begin
      armed_next = armed_reg;
      dg_next = dg_reg;
      fprev_next = armed_reg ? fcnt : '0;
      st_next = st_reg;
      bit_next = bit_reg;
      step_next = step_reg;
      acc_next = acc_reg;
      dac_next = DAC_CODE_O;
      mux_next = MUX_SEL_O;
      mux_ok_next = MUX_VALID_O;
      sample_next = SAMPLE_O;
      eoc_next = EOC_O;
      // Select high: link idle and ignored
      if (cs_s2_reg) begin
         armed_next = 1'b0;
         dg_next = '0;
      end else if (cs_fall) begin
         armed_next = 1'b0;
         dg_next = sac_pkg::DEGLITCH_LOAD;
      end else if (dg_reg != '0) begin
         dg_next = sac_pkg::DG_W'(dg_reg - 1'b1);
         if (dg_reg == sac_pkg::DG_ONE) begin
            armed_next = 1'b1;
         end
      end
      if (cs_fall) begin
         st_next = sac_pkg::CV_IDLE;
         sample_next = 1'b0;
         dac_next = sac_pkg::CODE_ZERO;
         eoc_next = 1'b1;
      end else begin
         case (st_reg)
            sac_pkg::CV_IDLE: begin
               if (smp_start) begin
                  mux_next = ad_s2_reg;
                  mux_ok_next = (ad_s2_reg <= sac_pkg::ADDR_LAST);
                  sample_next = 1'b1;
                  st_next = sac_pkg::CV_SAMPLE;
               end
            end
            sac_pkg::CV_SAMPLE: begin
               if (smp_hold) begin
                  sample_next = 1'b0;
                  eoc_next = 1'b0;
                  acc_next = sac_pkg::CODE_ZERO;
                  bit_next = sac_pkg::BIT_MSB;
                  dac_next = sac_pkg::CODE_ONE << sac_pkg::BIT_MSB;
                  step_next = sac_pkg::STEP_LOAD;
                  st_next = sac_pkg::CV_TRIAL;
               end
            end
            sac_pkg::CV_TRIAL: begin
               if (step_reg != '0) begin
                  // Let the array and comparator settle
                  step_next = sac_pkg::STEP_W'(step_reg - 1'b1);
               end else begin
                  acc_next = cmp_s2_reg ? trial : acc_reg;
                  if (bit_reg == sac_pkg::BIT_LSB) begin
                     if (ovr_s2_reg) begin
                        acc_next = sac_pkg::CODE_FULL;
                     end else if (und_s2_reg) begin
                        acc_next = sac_pkg::CODE_ZERO;
                     end
                     dac_next = sac_pkg::CODE_ZERO;
                     st_next = sac_pkg::CV_DONE;
                  end else begin
                     bit_next = 4'(bit_reg - 1'b1);
                     dac_next = sac_pkg::CODE_ONE << (bit_reg - 1'b1);
                     step_next = sac_pkg::STEP_LOAD;
                  end
               end
            end
            sac_pkg::CV_DONE: begin
               // Stalls here while the buffer is full
               if (push_ready) begin
                  eoc_next = 1'b1;
                  st_next = sac_pkg::CV_IDLE;
               end
            end
            default: begin
               st_next = sac_pkg::CV_IDLE;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         armed_reg <= 1'b0;
         dg_reg <= '0;
         fprev_reg <= '0;
         st_reg <= sac_pkg::CV_IDLE;
         bit_reg <= sac_pkg::BIT_MSB;
         step_reg <= '0;
         acc_reg <= sac_pkg::CODE_ZERO;
         DAC_CODE_O <= sac_pkg::CODE_ZERO;
         MUX_SEL_O <= '0;
         MUX_VALID_O <= 1'b1;
         SAMPLE_O <= 1'b0;
         EOC_O <= 1'b1;
      end else begin
         armed_reg <= armed_next;
         dg_reg <= dg_next;
         fprev_reg <= fprev_next;
         st_reg <= st_next;
         bit_reg <= bit_next;
         step_reg <= step_next;
         acc_reg <= acc_next;
         DAC_CODE_O <= dac_next;
         MUX_SEL_O <= mux_next;
         MUX_VALID_O <= mux_ok_next;
         SAMPLE_O <= sample_next;
         EOC_O <= eoc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result buffer and output shifter
   logic pop_valid, pop_ready;                          // Out of the result buffer
   logic [sac_pkg::RES_W-1:0] pop_data;
   logic [sac_pkg::RES_W-1:0] out_reg, out_next;        // Output result register
   logic data_next, oe_n_next;
   logic [sac_pkg::CNT_W-1:0] shift_pos;                // Bits already shifted
   // Two entries absorb a result finished while a transfer is shifting
   sac_fifo2 #(
      .W(sac_pkg::RES_W),
      .DEPTH(sac_pkg::FIFO_DEPTH)
   ) u_buf (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .in_valid_i(push_valid),
      .in_data_i(acc_reg),
      .in_ready_o(push_ready),
      .out_valid_o(pop_valid),
      .out_data_o(pop_data),
      .out_ready_i(pop_ready)
   );
   // Only refresh between frames, so a shift never sees a torn word;
   // with select held low throughout, the register does not refresh
   assign pop_ready = cs_s2_reg;
   assign shift_pos = armed_reg ? fcnt : '0;

   // Output next values
   always_comb begin
      out_next = out_reg;
      if (pop_valid && pop_ready) begin
         out_next = pop_data;
      end
      if (shift_pos < sac_pkg::FALL_HOLD) begin
         data_next = out_reg[4'(sac_pkg::BIT_MSB - shift_pos[3:0])];
      end else begin
         data_next = 1'b0;
      end
      oe_n_next = cs_s2_reg;
   end

   // Output registers
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         out_reg <= sac_pkg::CODE_ZERO;
         DATA_O <= 1'b0;
         DATA_OE_N_O <= 1'b1;
      end else begin
         out_reg <= out_next;
         DATA_O <= data_next;
         DATA_OE_N_O <= oe_n_next;
      end
   end

endmodule

// ===== bench/sac_top_sva.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module sac_top_chk (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CS_N_I,
   input wire logic DATA_OE_N_O,
   input wire logic SAMPLE_O,
   input wire logic [sac_pkg::ADDR_W-1:0] MUX_SEL_O,
   input wire logic MUX_VALID_O,
   input wire logic [sac_pkg::RES_W-1:0] DAC_CODE_O,
   input wire logic EOC_O
);
   // Cycles with select low, saturating so it never wraps
   logic [7:0] low_reg;
   always_ff @(posedge CLK_I) begin
      if (CS_N_I) begin
         low_reg <= 8'h00;
      end else if (low_reg != 8'hff) begin
         low_reg <= low_reg + 8'h01;
      end
   end
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   ////////////////////////////////////////////////////////////////////////////
   property p_oe_on; $fell(CS_N_I) |-> ##[2:4] !DATA_OE_N_O; endproperty
   a_oe_on: assert property (p_oe_on) else $error("data pin not driven");
   property p_oe_off; $rose(CS_N_I) |-> ##[2:4] DATA_OE_N_O; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data pin not released");
   property p_abort; $fell(CS_N_I) |-> ##[1:5] (EOC_O && !SAMPLE_O && ~|DAC_CODE_O); endproperty
   a_abort: assert property (p_abort) else $error("select fall left cycle running");
   property p_deglitch; $rose(SAMPLE_O) |-> low_reg > 8'(sac_pkg::DEGLITCH_CYC); endproperty
   a_deglitch: assert property (p_deglitch) else $error("sampling before wait");
   property p_first; $rose(|DAC_CODE_O) |-> DAC_CODE_O == 10'h200 && $fell(SAMPLE_O) && !EOC_O;
   endproperty
   a_first: assert property (p_first) else $error("bad conversion start");
   property p_shift; $changed(DAC_CODE_O) && |DAC_CODE_O && |$past(DAC_CODE_O)
      |-> DAC_CODE_O == ($past(DAC_CODE_O) >> 1); endproperty
   a_shift: assert property (p_shift) else $error("trial bit not next lower");
   property p_hold; $changed(DAC_CODE_O) && |DAC_CODE_O
      |=> ($stable(DAC_CODE_O) || ~|DAC_CODE_O) [*3]; endproperty
   a_hold: assert property (p_hold) else $error("trial step too short");
   property p_valid; MUX_VALID_O == (MUX_SEL_O <= sac_pkg::ADDR_LAST); endproperty
   a_valid: assert property (p_valid) else $error("input valid flag wrong");
endmodule
bind sac_top sac_top_chk u_chk (.CLK_I, .RST_I, .CS_N_I, .DATA_OE_N_O, .SAMPLE_O,
   .MUX_SEL_O, .MUX_VALID_O, .DAC_CODE_O, .EOC_O);

// ===== bench/sac_host.sv
// Host serial port and ideal analog front end
`timescale 1ns/1ps
module sac_host (
   input wire logic data_i,
   input wire logic data_oe_n_i,
   input wire logic [9:0] dac_code_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic addr_o,
   output logic comp_o
);
   localparam int HALF_NS = 240; // Just under the top serial rate
   logic [9:0] vin = 10'h000; // Analog level as an exact code
   // Exact code: a trial bit is kept iff it is set in the level
   assign comp_o = |(dac_code_i & vin);
   // Idle: clock still, select high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      addr_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One frame: address in, previous result out
   task automatic xfer(input logic [3:0] a, input int n, input int tail, output logic [9:0] rd);
      rd = 10'h000;
      cs_n_o <= 1'b0;
      #1500;
      for (int k = 1; k <= n; k++) begin
         addr_o <= (k <= 4) ? a[4-k] : ~addr_o;
         #HALF_NS;
         sclk_o <= 1'b1;
         // Released pin reads inverted
         if (k <= 10) begin
            rd[10-k] = data_oe_n_i ? ~data_i : data_i;
         end
         #HALF_NS;
         sclk_o <= 1'b0;
      end
      #tail;
      cs_n_o <= 1'b1;
      addr_o <= ~addr_o;
   endtask
   // Abort mid-conversion, not near its end
   task automatic abort_pulse();
      #80;
      cs_n_o <= 1'b0;
      #200;
      cs_n_o <= 1'b1;
   endtask
endmodule

// ===== bench/test_sac_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sac_top;
   logic CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic OVER_REF_I = 1'b0;
   logic UNDER_REF_I = 1'b0;
   logic SCLK_I;
   logic CS_N_I;
   logic ADDR_I;
   logic COMP_I;
   logic DATA_O;
   logic DATA_OE_N_O;
   logic SAMPLE_O;
   logic MUX_VALID_O;
   logic EOC_O;
   logic [3:0] MUX_SEL_O;
   logic [9:0] DAC_CODE_O;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [9:0] prev_res = 10'h000; // Result the next frame must show
   logic [9:0] rd;
   always #4 CLK_I = ~CLK_I;
   sac_top DUT (.CLK_I, .RST_I, .SCLK_I, .CS_N_I, .ADDR_I, .COMP_I, .OVER_REF_I,
      .UNDER_REF_I, .DATA_O, .DATA_OE_N_O, .SAMPLE_O, .MUX_SEL_O, .MUX_VALID_O,
      .DAC_CODE_O, .EOC_O);
   sac_host u_host (.data_i(DATA_O), .data_oe_n_i(DATA_OE_N_O), .dac_code_i(DAC_CODE_O),
      .sclk_o(SCLK_I), .cs_n_o(CS_N_I), .addr_o(ADDR_I), .comp_o(COMP_I));
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Single exit point
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard, about twice the expected run
   always @(posedge CLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Full frame, then idle so the result reaches the output register
   task automatic frame(input logic [3:0] a, input logic [9:0] v, input logic [9:0] exp);
      u_host.vin = v;
      u_host.xfer(a, 16, 240, rd);
      check(rd, prev_res);
      check(MUX_SEL_O, a);
      check(MUX_VALID_O, a <= sac_pkg::ADDR_LAST);
      repeat (100) @(posedge CLK_I);
      check(DATA_OE_N_O, 1'b1);
      check(EOC_O, 1'b1);
      prev_res = exp;
   endtask
   // Idle outputs after reset
   task automatic t_reset();
      @(posedge CLK_I);
      #1;
      check({EOC_O, DATA_OE_N_O, SAMPLE_O, MUX_SEL_O}, 10'h060);
      check(DAC_CODE_O, 10'h000);
   endtask
   // Every address code, each read back by the next frame
   task automatic t_codes();
      for (int a = 0; a < 16; a++) begin
         frame(4'(a), {4'(a), 6'h15}, {4'(a), 6'h15});
      end
   endtask
   // Reference limits override the bit decisions
   task automatic t_clamp();
      @(posedge CLK_I);
      OVER_REF_I <= 1'b1;
      frame(4'h3, 10'h155, 10'h3ff);
      OVER_REF_I <= 1'b0;
      UNDER_REF_I <= 1'b1;
      frame(4'h3, 10'h2aa, 10'h000);
      UNDER_REF_I <= 1'b0;
      frame(4'h5, 10'h0f0, 10'h0f0);
   endtask
   // Select falls mid-conversion: old result must survive
   task automatic t_abort();
      u_host.vin = 10'h333;
      u_host.xfer(4'h6, 10, 100, rd);
      check(rd, prev_res);
      u_host.abort_pulse();
      repeat (100) @(posedge CLK_I);
      frame(4'h7, 10'h111, 10'h111);
      frame(4'h0, 10'h000, 10'h000);
   endtask
   initial begin
      repeat (5) @(posedge CLK_I);
      RST_I <= 1'b0;
      t_reset();
      t_codes();
      t_clamp();
      t_abort();
      tally_and_finish();
   end
endmodule
